// ==== verilog/shplim_top.sv ====
// Safe homing, home offset and limited position window monitoring
`timescale 1ns/1ps
`default_nettype none
`include "shplim_defs.svh"

// Operation
// RULE1: Reference pulse homing needs a rotary safety encoder pulsing once per turn; encoder_rotary is not checked.
// RULE2: After switch edge, ignore pulses over blocking distance; home on next pulse.
// RULE3: Homing valid only with unchanged direction and speed under trigger limit.
// RULE4: Direction reversal during pulse search discards it; switch must be passed again.
// RULE5: Overspeed during pulse search enters acknowledgeable functional fail-safe.
// RULE6: Functional fail-safe clears no-error output and removes drive torque.
// RULE7: Offset modes add offset to encoder position and ignore home switch.
// RULE8: Correction mode wraps offset by counting range if outside max limits.
// RULE9: Offset mode with non-absolute encoder enters non-acknowledgeable fail-safe.
// RULE10: Position window larger than counting range enters non-acknowledgeable fail-safe.
// RULE11: Correction mode without maximum position monitor enters non-acknowledgeable fail-safe.
// RULE12: Non-acknowledgeable fail-safe leaves only by power cycle, never acknowledge.
// RULE13: Movement range must not exceed safe counting range for correction.
// RULE14: Limited position request is active low.
// RULE15: Wait configured start delay in microseconds before window monitoring.
// RULE16: Active monitoring compares position with lower and upper limits.
// RULE17: Hold deceleration ramp slope, default 1073676289.
// RULE18: Four homing modes; direct is default.
// RULE19: Keep standstill speed and position tolerances for direction monitoring; only pos_tolerance is used, speed_tolerance is not.
// RULE20: Without reference pulse, adopt home position at the switch edge.
// RULE21: Homing not done within monitoring time enters functional fail-safe.
// RULE22: Blocking distance counts from the switch edge, in encoder counts.
// RULE23: Reverse motion beyond position tolerance counts as direction reversal.
// RULE24: New command or discarded search resets blocking and pulse state.
module shplim_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire shplim_pkg::shplim_cfg_type cfg,
    input wire logic [31:0] homing_timeout_cycles,
    input wire logic homing_request,
    input wire logic home_switch_in,
    input wire logic ref_pulse_in,
    input wire logic [31:0] encoder_position,
    input wire logic [31:0] encoder_speed,
    input wire logic encoder_valid,
    input wire logic limited_position_request_n,
    input wire logic error_ack,
    output logic no_function_error_out,
    output logic fail_safe_out,
    output logic torque_enable,
    output logic safe_position_valid,
    output logic [31:0] machine_position,
    output logic limited_position_monitor,
    output logic limited_position_violation,
    output logic [31:0] decel_ramp_out
);
    shplim_pkg::shplim_home_state_type home_reg;
    shplim_pkg::shplim_slp_state_type slp_reg;
    logic func_err_reg;
    logic fail_safe_reg;
    logic req_d_reg;
    logic sw_d_reg;
    logic pulse_d_reg;
    logic [31:0] offset_reg;
    logic [31:0] anchor_reg;
    logic [31:0] extreme_reg;
    logic [31:0] home_timer_reg;
    logic [31:0] delay_us_reg;
    logic [7:0] tick_reg;
    logic [31:0] raw_sum;
    logic [31:0] travelled;
    logic [31:0] back_move;
    logic move_pos;
    logic speed_ok;
    logic sw_edge;
    logic pulse_rise;
    logic home_cmd;
    logic cfg_bad;
    logic reverse_seen;
    logic overspeed_search;
    logic timeout_hit;
    logic slp_fault;
    logic in_search;

    function automatic logic [31:0] abs_val(input logic [31:0] v);
        abs_val = v[31] ? 32'(-v) : v;
    endfunction

    function automatic logic in_window(input logic [31:0] p, input logic [31:0] lo,
                                       input logic [31:0] hi);
        in_window = ($signed(p) >= $signed(lo)) && ($signed(p) <= $signed(hi));
    endfunction

    assign move_pos = ~encoder_speed[31];
    assign speed_ok = abs_val(encoder_speed) <= cfg.max_trigger_speed; // RULE3
    assign home_cmd = homing_request & ~req_d_reg;
    // Edge polarity is judged in the direction of travel
    assign sw_edge = (home_switch_in != sw_d_reg) &&
        ((home_switch_in ^ ~move_pos) == cfg.edge_positive) &&
        (move_pos == cfg.trigger_positive) && speed_ok;
    assign pulse_rise = ref_pulse_in & ~pulse_d_reg;
    assign raw_sum = 32'(encoder_position + cfg.home_offset); // RULE7
    assign travelled = abs_val(32'(encoder_position - anchor_reg)); // RULE22
    // Motion against the trigger direction, measured from the furthest point reached
    assign back_move = cfg.trigger_positive ? 32'(extreme_reg - encoder_position)
                                            : 32'(encoder_position - extreme_reg);
    assign in_search = (home_reg == shplim_pkg::SHPLIM_BLOCKING) ||
                       (home_reg == shplim_pkg::SHPLIM_WAIT_PULSE);
    assign reverse_seen = in_search && !back_move[31] &&
                          (back_move > cfg.pos_tolerance); // RULE19 RULE23
    assign overspeed_search = in_search && !speed_ok; // RULE5
    assign timeout_hit = (home_reg == shplim_pkg::SHPLIM_WAIT_EDGE || in_search) &&
                         (home_timer_reg >= homing_timeout_cycles); // RULE21

    // Configuration consistency, checked continuously
    always_comb begin
        cfg_bad = 1'b0;
        if ((cfg.mode == shplim_pkg::SHPLIM_MODE_OFFSET_E ||
             cfg.mode == shplim_pkg::SHPLIM_MODE_OFFCOR_E) && !cfg.encoder_absolute) begin
            cfg_bad = 1'b1; // RULE9
        end
        if (32'(cfg.slp_upper - cfg.slp_lower) > cfg.counting_range) begin
            cfg_bad = 1'b1; // RULE10
        end
        if (cfg.max_pos_used && 32'(cfg.smp_upper - cfg.smp_lower) > cfg.counting_range) begin
            cfg_bad = 1'b1; // RULE10
        end
        if (cfg.mode == shplim_pkg::SHPLIM_MODE_OFFCOR_E && !cfg.max_pos_used) begin
            cfg_bad = 1'b1; // RULE11
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_d_reg <= 1'b0;
            sw_d_reg <= home_switch_in;
            pulse_d_reg <= ref_pulse_in;
        end else begin
            req_d_reg <= homing_request;
            sw_d_reg <= home_switch_in;
            pulse_d_reg <= ref_pulse_in;
        end
    end

    // Latched: only a power cycle (reset) clears it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fail_safe_reg <= 1'b0;
        end else if (cfg_bad) begin
            fail_safe_reg <= 1'b1; // RULE12
        end
    end

    // Homing sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            home_reg <= shplim_pkg::SHPLIM_IDLE;
            offset_reg <= 32'h0000_0000;
            anchor_reg <= 32'h0000_0000;
            extreme_reg <= 32'h0000_0000;
            home_timer_reg <= 32'h0000_0000;
        end else if (func_err_reg || fail_safe_reg) begin
            home_reg <= shplim_pkg::SHPLIM_IDLE;
            home_timer_reg <= 32'h0000_0000;
        end else if (home_cmd) begin
            home_timer_reg <= 32'h0000_0000;
            anchor_reg <= encoder_position; // RULE24
            extreme_reg <= encoder_position; // RULE24
            case (cfg.mode) // RULE18
                shplim_pkg::SHPLIM_MODE_REFSW_E: begin
                    home_reg <= shplim_pkg::SHPLIM_WAIT_EDGE;
                end
                shplim_pkg::SHPLIM_MODE_OFFSET_E: begin
                    offset_reg <= cfg.home_offset; // RULE7
                    home_reg <= shplim_pkg::SHPLIM_HOMED;
                end
                shplim_pkg::SHPLIM_MODE_OFFCOR_E: begin
                    // Shift by one counting range toward the movement range
                    if ($signed(raw_sum) < $signed(cfg.smp_lower)) begin
                        offset_reg <= 32'(cfg.home_offset + cfg.counting_range); // RULE8
                    end else if ($signed(raw_sum) > $signed(cfg.smp_upper)) begin
                        offset_reg <= 32'(cfg.home_offset - cfg.counting_range); // RULE8
                    end else begin
                        offset_reg <= cfg.home_offset;
                    end
                    home_reg <= shplim_pkg::SHPLIM_HOMED;
                end
                default: begin
                    offset_reg <= 32'h0000_0000;
                    home_reg <= shplim_pkg::SHPLIM_HOMED;
                end
            endcase
        end else begin
            if (home_reg != shplim_pkg::SHPLIM_HOMED && home_reg != shplim_pkg::SHPLIM_IDLE) begin
                home_timer_reg <= 32'(home_timer_reg + 32'h0000_0001);
            end
            if (in_search && (cfg.trigger_positive ?
                    $signed(encoder_position) > $signed(extreme_reg) :
                    $signed(encoder_position) < $signed(extreme_reg))) begin
                extreme_reg <= encoder_position;
            end
            case (home_reg)
                shplim_pkg::SHPLIM_WAIT_EDGE: begin
                    if (sw_edge) begin
                        anchor_reg <= encoder_position;
                        extreme_reg <= encoder_position;
                        if (cfg.ref_pulse_used) begin
                            home_reg <= shplim_pkg::SHPLIM_BLOCKING; // RULE2
                        end else begin
                            offset_reg <= 32'(cfg.home_offset - encoder_position); // RULE20
                            home_reg <= shplim_pkg::SHPLIM_HOMED;
                        end
                    end
                end
                shplim_pkg::SHPLIM_BLOCKING: begin
                    if (reverse_seen) begin
                        home_reg <= shplim_pkg::SHPLIM_WAIT_EDGE; // RULE4
                    end else if (travelled >= cfg.blocking_counts) begin
                        home_reg <= shplim_pkg::SHPLIM_WAIT_PULSE; // RULE2
                    end
                end
                shplim_pkg::SHPLIM_WAIT_PULSE: begin
                    if (reverse_seen) begin
                        home_reg <= shplim_pkg::SHPLIM_WAIT_EDGE; // RULE4
                    end else if (pulse_rise && speed_ok) begin
                        offset_reg <= 32'(cfg.home_offset - encoder_position); // RULE2
                        home_reg <= shplim_pkg::SHPLIM_HOMED; // RULE3
                    end
                end
                shplim_pkg::SHPLIM_HOMED: begin
                    if (!encoder_valid) begin
                        home_reg <= shplim_pkg::SHPLIM_IDLE;
                    end
                end
                default: begin
                    home_reg <= home_reg;
                end
            endcase
        end
    end

    // Microsecond tick divider for the start delay
    always_ff @(posedge clk) begin
        if (sys_rst || slp_reg != shplim_pkg::SHPLIM_SLP_DELAY) begin
            tick_reg <= 8'h00;
        end else if (tick_reg == 8'(`SHPLIM_TICKS_PER_US - 1)) begin
            tick_reg <= 8'h00;
        end else begin
            tick_reg <= 8'(tick_reg + 8'h01);
        end
    end

    assign slp_fault = (slp_reg == shplim_pkg::SHPLIM_SLP_ACTIVE &&
        (!in_window(machine_position, cfg.slp_lower, cfg.slp_upper) ||
         !safe_position_valid)) ||
        (slp_reg != shplim_pkg::SHPLIM_SLP_OFF && !safe_position_valid);

    // Limited position window monitor
    always_ff @(posedge clk) begin
        if (sys_rst || func_err_reg || fail_safe_reg) begin
            slp_reg <= shplim_pkg::SHPLIM_SLP_OFF;
            delay_us_reg <= 32'h0000_0000;
        end else if (limited_position_request_n) begin
            slp_reg <= shplim_pkg::SHPLIM_SLP_OFF;
            delay_us_reg <= 32'h0000_0000;
        end else begin
            case (slp_reg)
                shplim_pkg::SHPLIM_SLP_OFF: begin
                    slp_reg <= shplim_pkg::SHPLIM_SLP_DELAY; // RULE14
                    delay_us_reg <= 32'h0000_0000;
                end
                shplim_pkg::SHPLIM_SLP_DELAY: begin
                    if (delay_us_reg >= cfg.slp_delay_us) begin
                        slp_reg <= shplim_pkg::SHPLIM_SLP_ACTIVE; // RULE15
                    end else if (tick_reg == 8'(`SHPLIM_TICKS_PER_US - 1)) begin
                        delay_us_reg <= 32'(delay_us_reg + 32'h0000_0001);
                    end
                end
                default: begin
                    slp_reg <= slp_reg;
                end
            endcase
        end
    end

    // Acknowledgeable functional error; a new event wins over acknowledge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            func_err_reg <= 1'b0;
        end else if (overspeed_search || timeout_hit || slp_fault) begin
            func_err_reg <= 1'b1; // RULE5
        end else if (error_ack) begin
            func_err_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            machine_position <= 32'h0000_0000;
            limited_position_violation <= 1'b0;
            decel_ramp_out <= `SHPLIM_DECEL_DEFAULT;
        end else begin
            machine_position <= 32'(encoder_position + offset_reg); // RULE7
            limited_position_violation <= slp_fault; // RULE16
            decel_ramp_out <= cfg.decel_ramp; // RULE17
        end
    end

    // Speed tolerance is carried in the config; no logic in the project uses it
    assign no_function_error_out = ~func_err_reg & ~fail_safe_reg; // RULE6
    assign torque_enable = ~func_err_reg & ~fail_safe_reg; // RULE6
    assign fail_safe_out = fail_safe_reg;
    assign safe_position_valid = (home_reg == shplim_pkg::SHPLIM_HOMED) && encoder_valid;
    assign limited_position_monitor = (slp_reg == shplim_pkg::SHPLIM_SLP_ACTIVE); // RULE16
    // RULE19: pos_tolerance used by reversal detection
endmodule
`default_nettype wire

// ==== shared/shplim_defs.svh ====
// Constants for the safe homing and limited position block
`ifndef SHPLIM_DEFS_SVH
`define SHPLIM_DEFS_SVH
`define SHPLIM_POS_W 32
`define SHPLIM_MODE_DIRECT 2'h0
`define SHPLIM_MODE_REF_SWITCH 2'h1
`define SHPLIM_MODE_OFFSET 2'h2
`define SHPLIM_MODE_OFFSET_CORR 2'h3
`define SHPLIM_DECEL_DEFAULT 32'h3FFF_0001
`define SHPLIM_CLK_MHZ 100
`define SHPLIM_DELAY_W 32
`define SHPLIM_TICK_W 8
`define SHPLIM_TICKS_PER_US (`SHPLIM_CLK_MHZ)
`endif

// ==== shared/shplim_pkg.sv ====
// Types for the safe homing and limited position block
package shplim_pkg;
    typedef enum logic [1:0] {
        SHPLIM_MODE_DIRECT_E = 2'b00,
        SHPLIM_MODE_REFSW_E = 2'b01,
        SHPLIM_MODE_OFFSET_E = 2'b10,
        SHPLIM_MODE_OFFCOR_E = 2'b11
    } shplim_mode_type;

    typedef struct packed {
        shplim_mode_type mode;
        logic edge_positive;
        logic trigger_positive;
        logic ref_pulse_used;
        logic max_pos_used;
        logic encoder_absolute;
        logic encoder_rotary;
        logic [31:0] home_offset;
        logic [31:0] max_trigger_speed;
        logic [31:0] blocking_counts;
        logic [31:0] pos_tolerance;
        logic [31:0] speed_tolerance;
        logic [31:0] slp_lower;
        logic [31:0] slp_upper;
        logic [31:0] smp_lower;
        logic [31:0] smp_upper;
        logic [31:0] counting_range;
        logic [31:0] slp_delay_us;
        logic [31:0] decel_ramp;
    } shplim_cfg_type;

    typedef enum logic [2:0] {
        SHPLIM_IDLE = 3'b000,
        SHPLIM_WAIT_EDGE = 3'b001,
        SHPLIM_BLOCKING = 3'b010,
        SHPLIM_WAIT_PULSE = 3'b011,
        SHPLIM_HOMED = 3'b100
    } shplim_home_state_type;

    typedef enum logic [1:0] {
        SHPLIM_SLP_OFF = 2'b00,
        SHPLIM_SLP_DELAY = 2'b01,
        SHPLIM_SLP_ACTIVE = 2'b10
    } shplim_slp_state_type;
endpackage

// ==== verification/shplim_monitor.sv ====
// Port-level assertions for the safe homing and limited position block
`timescale 1ns/1ps
`default_nettype none
`include "shplim_defs.svh"
module shplim_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire shplim_pkg::shplim_cfg_type cfg,
    input wire logic homing_request,
    input wire logic [31:0] encoder_position,
    input wire logic limited_position_request_n,
    input wire logic no_function_error_out,
    input wire logic fail_safe_out,
    input wire logic torque_enable,
    input wire logic safe_position_valid,
    input wire logic [31:0] machine_position,
    input wire logic limited_position_monitor,
    input wire logic limited_position_violation,
    input wire logic [31:0] decel_ramp_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] low_cnt_reg;
    logic out_win;
    // Cycles the request has been held low, to bound the start delay
    always_ff @(posedge clk) begin
        if (sys_rst || limited_position_request_n) begin
            low_cnt_reg <= 32'h0000_0000;
        end else begin
            low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
        end
    end
    assign out_win = $signed(machine_position) < $signed(cfg.slp_lower)
        || $signed(machine_position) > $signed(cfg.slp_upper);
    torque_off_a: assert property (!no_function_error_out |-> !torque_enable)
        else $error("torque enabled during functional error");
    fail_latch_a: assert property (fail_safe_out |=> fail_safe_out)
        else $error("fail-safe state left without reset");
    offset_pos_a: assert property ((safe_position_valid
        && cfg.mode == shplim_pkg::SHPLIM_MODE_OFFSET_E)
        |=> machine_position == $past(encoder_position) + $past(cfg.home_offset))
        else $error("offset machine position wrong");
    abs_need_a: assert property ((cfg.mode[1] && !cfg.encoder_absolute)
        |-> ##[1:2] fail_safe_out) else $error("offset mode on relative encoder");
    smp_need_a: assert property ((!cfg.max_pos_used
        && cfg.mode == shplim_pkg::SHPLIM_MODE_OFFCOR_E) |-> ##[1:2] fail_safe_out)
        else $error("correction mode without maximum position monitor");
    slp_delay_a: assert property ($rose(limited_position_monitor)
        |-> !limited_position_request_n && low_cnt_reg >= cfg.slp_delay_us * `SHPLIM_TICKS_PER_US)
        else $error("window monitoring started early");
    win_trip_a: assert property ((limited_position_monitor && out_win)
        |-> ##[1:2] limited_position_violation) else $error("window exit not flagged");
    viol_err_a: assert property (limited_position_violation
        |-> ##[0:1] !no_function_error_out) else $error("violation kept no-error high");
    decel_rst_a: assert property (disable iff (1'b0) sys_rst
        |=> decel_ramp_out == `SHPLIM_DECEL_DEFAULT) else $error("ramp default wrong");
    direct_home_a: assert property (($rose(homing_request) && !fail_safe_out
        && no_function_error_out && cfg.mode == shplim_pkg::SHPLIM_MODE_DIRECT_E)
        |=> safe_position_valid) else $error("direct homing not taken");
    cover property ($rose(safe_position_valid));
    cover property ($rose(fail_safe_out));
    cover property ($rose(limited_position_violation));
    cover property ($fell(no_function_error_out));
endmodule
`default_nettype wire

// ==== verification/shplim_axis_model.sv ====
// Encoder axis model: position, speed, home switch and once-per-turn pulse
`timescale 1ns/1ps
`default_nettype none
module shplim_axis_model #(
    parameter int SW_POS = 1000,
    parameter int TURN_BITS = 12
) (
    input wire logic clk,
    input wire logic [31:0] speed,
    input wire logic ld,
    input wire logic [31:0] ld_pos,
    output logic [31:0] encoder_position,
    output logic [31:0] encoder_speed,
    output logic home_switch_in,
    output logic ref_pulse_in
);
    logic [31:0] pos_next;
    assign pos_next = ld ? ld_pos : encoder_position + speed;
    always_ff @(posedge clk) begin
        encoder_position <= pos_next;
        encoder_speed <= speed;
        // A loaded jump is not a turn overflow, so it gives no pulse
        ref_pulse_in <= !ld && pos_next[31:TURN_BITS] != encoder_position[31:TURN_BITS];
    end
    assign home_switch_in = $signed(encoder_position) >= SW_POS;
endmodule
`default_nettype wire

// ==== verification/shplim_top_tb.sv ====
// Self-checking testbench for the safe homing and limited position block
`timescale 1ns/1ps
`default_nettype none
`include "shplim_defs.svh"
module shplim_top_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    shplim_pkg::shplim_cfg_type cfg;
    logic [31:0] homing_timeout_cycles = 32'h0001_0000;
    logic homing_request = 1'b0;
    logic encoder_valid = 1'b1;
    logic limited_position_request_n = 1'b1;
    logic error_ack = 1'b0;
    logic ld = 1'b1;
    logic [31:0] ld_pos = 32'h0000_0000;
    logic [31:0] speed = 32'h0000_0000;
    logic home_switch_in, ref_pulse_in, no_function_error_out, fail_safe_out, torque_enable;
    logic safe_position_valid, limited_position_monitor, limited_position_violation;
    logic [31:0] encoder_position, encoder_speed, machine_position, decel_ramp_out;
    int errors = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    shplim_axis_model axis (.clk, .speed, .ld, .ld_pos, .encoder_position,
        .encoder_speed, .home_switch_in, .ref_pulse_in);
    shplim_top DUT (.clk, .sys_rst, .cfg, .homing_timeout_cycles, .homing_request,
        .home_switch_in, .ref_pulse_in, .encoder_position, .encoder_speed, .encoder_valid,
        .limited_position_request_n, .error_ack, .no_function_error_out, .fail_safe_out,
        .torque_enable, .safe_position_valid, .machine_position, .limited_position_monitor,
        .limited_position_violation, .decel_ramp_out);
    function automatic shplim_pkg::shplim_cfg_type base_cfg(input shplim_pkg::shplim_mode_type m);
        shplim_pkg::shplim_cfg_type c;
        c = '0;
        c.mode = m;
        {c.edge_positive, c.trigger_positive, c.max_pos_used} = 3'h7;
        {c.encoder_absolute, c.encoder_rotary} = 2'h3;
        c.max_trigger_speed = 32'h0000_0064;
        c.blocking_counts = 32'h0000_0DAC;
        c.pos_tolerance = 32'h0000_0032;
        c.slp_lower = 32'hFFFF_FF9C;
        c.slp_upper = 32'h0000_01F4;
        c.smp_lower = 32'hFFFF_EC78;
        c.smp_upper = 32'h0000_4E20;
        c.counting_range = 32'h0001_0000;
        c.slp_delay_us = 32'h0000_0001;
        c.decel_ramp = `SHPLIM_DECEL_DEFAULT;
        return c;
    endfunction
    function automatic logic flag(input int w);
        case (w)
            0: return safe_position_valid;
            1: return fail_safe_out;
            2: return limited_position_monitor;
            default: return limited_position_violation;
        endcase
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_for(input int w, input int lim);
        for (int i = 0; i < lim && flag(w) !== 1'b1; i++) tick(1);
    endtask
    // Reset with the axis parked at a known position
    task automatic rst(input logic [31:0] pos);
        {sys_rst, ld, homing_request, limited_position_request_n, error_ack} = 5'h1A;
        ld_pos = pos;
        speed = 32'h0000_0000;
        tick(6);
        {sys_rst, ld} = 2'h0;
        tick(1);
    endtask
    task automatic home();
        homing_request = 1'b1;
        tick(1);
        homing_request = 1'b0;
    endtask
    task automatic t_reset_direct();
        cfg = base_cfg(shplim_pkg::SHPLIM_MODE_DIRECT_E);
        rst(32'h0000_0000);
        chk("no_error", 32'h1, no_function_error_out);
        chk("torque", 32'h1, torque_enable);
        chk("decel", `SHPLIM_DECEL_DEFAULT, decel_ramp_out);
        chk("valid_rst", 32'h0, safe_position_valid);
        home();
        wait_for(0, 4);
        chk("direct_valid", 32'h1, safe_position_valid);
    endtask
    task automatic t_offset(input shplim_pkg::shplim_mode_type m, input logic [31:0] pos,
        input logic [31:0] exp);
        cfg = base_cfg(m);
        cfg.home_offset = m[0] ? 32'h0000_0064 : 32'h0000_0123;
        rst(pos);
        home();
        wait_for(0, 4);
        tick(2);
        chk("offset_pos", exp, machine_position);
        ld_pos = 32'h0000_044C;
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
        tick(3);
        chk("switch_ignored", 32'h1, safe_position_valid);
    endtask
    task automatic t_ref(input logic pulse_used, input int back);
        cfg = base_cfg(shplim_pkg::SHPLIM_MODE_REFSW_E);
        cfg.ref_pulse_used = pulse_used;
        rst(32'h0000_0000);
        home();
        speed = 32'h0000_0014;
        if (!pulse_used) begin
            wait_for(0, 80);
            chk("nopulse_home", 32'h1, safe_position_valid);
        end else if (back == 0) begin
            tick(215);
            chk("blocked_pulse", 32'h0, safe_position_valid);
            wait_for(0, 250);
            chk("pulse_home", 32'h1, safe_position_valid);
        end else begin
            tick(75);
            speed = 32'hFFFF_FFEC;
            tick(back);
            speed = 32'h0000_0014;
            wait_for(0, 420);
            chk("reversed_search", 32'h0, safe_position_valid);
        end
        speed = 32'h0000_0000;
    endtask
    task automatic t_overspeed();
        cfg = base_cfg(shplim_pkg::SHPLIM_MODE_REFSW_E);
        cfg.ref_pulse_used = 1'b1;
        rst(32'h0000_0000);
        home();
        speed = 32'h0000_0014;
        tick(60);
        speed = 32'h0000_00C8;
        tick(3);
        chk("overspeed_err", 32'h0, no_function_error_out);
        chk("overspeed_torque", 32'h0, torque_enable);
        speed = 32'h0000_0000;
        error_ack = 1'b1;
        tick(2);
        error_ack = 1'b0;
        tick(1);
        chk("ack_clears", 32'h1, no_function_error_out);
        homing_timeout_cycles = 32'h0000_0014;
        home();
        tick(25);
        chk("timeout_err", 32'h0, no_function_error_out);
        homing_timeout_cycles = 32'h0001_0000;
    endtask
    task automatic t_cfg_faults();
        for (int i = 0; i < 3; i++) begin
            cfg = base_cfg(i == 2 ? shplim_pkg::SHPLIM_MODE_OFFCOR_E
                : i == 0 ? shplim_pkg::SHPLIM_MODE_OFFSET_E : shplim_pkg::SHPLIM_MODE_DIRECT_E);
            cfg.encoder_absolute = i != 0;
            cfg.slp_upper = i == 1 ? 32'h0002_0000 : 32'h0000_01F4;
            cfg.max_pos_used = i != 2;
            rst(32'h0000_0000);
            wait_for(1, 4);
            chk("cfg_fault", 32'h1, fail_safe_out);
            error_ack = 1'b1;
            tick(3);
            error_ack = 1'b0;
            chk("ack_ignored", 32'h1, fail_safe_out);
        end
    endtask
    task automatic t_slp();
        cfg = base_cfg(shplim_pkg::SHPLIM_MODE_OFFSET_E);
        cfg.decel_ramp = 32'h0000_1234;
        rst(32'h0000_0000);
        chk("decel_copy", 32'h0000_1234, decel_ramp_out);
        home();
        wait_for(0, 4);
        limited_position_request_n = 1'b0;
        tick(50);
        chk("slp_early", 32'h0, limited_position_monitor);
        wait_for(2, 60);
        chk("slp_on", 32'h1, limited_position_monitor);
        chk("slp_inside", 32'h0, limited_position_violation);
        speed = 32'h0000_0032;
        wait_for(3, 20);
        chk("slp_exit", 32'h1, limited_position_violation);
        tick(2);
        chk("slp_err", 32'h0, no_function_error_out);
        limited_position_request_n = 1'b1;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #200_000;
        errors++;
        end_of_test();
    end
    initial begin
        cfg = base_cfg(shplim_pkg::SHPLIM_MODE_DIRECT_E);
        t_reset_direct();
        t_offset(shplim_pkg::SHPLIM_MODE_OFFSET_E, 32'h0000_0384, 32'h0000_04A7);
        t_offset(shplim_pkg::SHPLIM_MODE_OFFCOR_E, 32'h0000_F1CC, 32'(62000 - 65536));
        t_ref(1'b0, 0);
        t_ref(1'b1, 0);
        t_ref(1'b1, 10);
        t_overspeed();
        t_cfg_faults();
        t_slp();
        end_of_test();
    end
endmodule
bind shplim_top shplim_monitor mon (.clk, .sys_rst, .cfg, .homing_request, .encoder_position,
    .limited_position_request_n, .no_function_error_out, .fail_safe_out, .torque_enable,
    .safe_position_valid, .machine_position, .limited_position_monitor,
    .limited_position_violation, .decel_ramp_out);
`default_nettype wire
